//--- inc/tw_defines.svh
// Purpose: Named constants of the two-wire slave receiver
// Assumes: Included by bare name after the package
// Notes:   Offsets are register indices on the plain port
`ifndef TW_DEFINES_SVH
`define TW_DEFINES_SVH

// ----------------------------------------------------------
// Register indices
// ----------------------------------------------------------
`define TW_REG_CONTROL 2'h0
`define TW_REG_STATUS  2'h1
`define TW_REG_DATA    2'h2
`define TW_REG_ADDRESS 2'h3

// ----------------------------------------------------------
// Control register bit positions
// ----------------------------------------------------------
`define TW_CB_FLAG   7
`define TW_CB_ACK    6
`define TW_CB_START  5
`define TW_CB_STOP   4
`define TW_CB_WCOL   3
`define TW_CB_ENABLE 2
`define TW_CB_IRQEN  0

// ----------------------------------------------------------
// Status codes, prescaler bits zero
// ----------------------------------------------------------
`define TW_ST_OWN_ADDR    8'h60
`define TW_ST_ARB_OWN     8'h68
`define TW_ST_GEN_ADDR    8'h70
`define TW_ST_ARB_GEN     8'h78
`define TW_ST_OWN_ACK     8'h80
`define TW_ST_OWN_NACK    8'h88
`define TW_ST_GEN_ACK     8'h90
`define TW_ST_GEN_NACK    8'h98
`define TW_ST_STOP_RESTRT 8'hA0
`define TW_ST_IDLE        8'hF8

// ----------------------------------------------------------
// Field layout and reset values
// ----------------------------------------------------------
`define TW_GEN_CALL_ADDR 7'h00
`define TW_BYTE_BITS     4'h8
`define TW_RESET_BYTE    8'h00
`define TW_PRESC_MSB     1
`endif

//--- inc/tw_pkg.sv
// Purpose: Types shared by the two-wire slave receiver files
// Assumes: Nothing
// Notes:   States are one-hot
package tw_pkg;
  typedef enum logic [6:0] {
    S_IDLE = 7'b0000001,
    S_ADDR = 7'b0000010,
    S_ACKA = 7'b0000100,
    S_DATA = 7'b0001000,
    S_ACKD = 7'b0010000,
    S_WAIT = 7'b0100000,
    S_SKIP = 7'b1000000
  } rx_state_t;
endpackage : tw_pkg

//--- inc/tw_link_if.sv
// Purpose: Carries sampled bus events between the receiver modules
// Assumes: All signals on the system clock
// Notes:   Events are one-cycle pulses
`timescale 1ns/1ps
`default_nettype none
interface tw_link_if;
  logic       sclRise;
  logic       sclFall;
  logic       startSeen;
  logic       stopSeen;
  logic       sdaLevel;
  logic       byteDone;
  logic       ninthDone;
  logic [7:0] shiftByte;
  modport sampler (output sclRise, sclFall, startSeen, stopSeen,
                   sdaLevel);
  modport shifter (input sclRise, startSeen, stopSeen, sdaLevel,
                   output byteDone, ninthDone, shiftByte);
  modport core    (input sclRise, sclFall, startSeen, stopSeen,
                   byteDone, ninthDone, shiftByte);
endinterface : tw_link_if
`default_nettype wire

//--- design/line_sampler.sv
// Purpose: Synchronises SCL and SDA and finds edges and conditions
// Assumes: Bus clock far slower than the system clock
// Notes:   Second stage alone feeds the edge logic
`timescale 1ns/1ps
`default_nettype none
module line_sampler (
  input  wire logic clock,
  input  wire logic rst,
  input  wire logic sclIn,
  input  wire logic sdaIn,
  tw_link_if.sampler link
);
  logic [1:0] sclSync;
  logic [1:0] sdaSync;
  logic       sclLast;
  logic       sdaLast;

  // Two-stage synchronisers, then one history stage
  always_ff @(posedge clock) begin
    if (rst) begin
      sclSync <= 2'h3;
      sdaSync <= 2'h3;
      sclLast <= 1'b1;
      sdaLast <= 1'b1;
    end else begin
      sclSync <= {sclSync[0], sclIn};
      sdaSync <= {sdaSync[0], sdaIn};
      sclLast <= sclSync[1];
      sdaLast <= sdaSync[1];
    end
  end

  // Edges, and SDA moving while SCL stays high
  assign link.sclRise   = sclSync[1] & ~sclLast;
  assign link.sclFall   = ~sclSync[1] & sclLast;
  assign link.startSeen = sclSync[1] & sclLast & sdaLast & ~sdaSync[1];
  assign link.stopSeen  = sclSync[1] & sclLast & ~sdaLast & sdaSync[1];
  assign link.sdaLevel  = sdaSync[1];
endmodule : line_sampler
`default_nettype wire

//--- design/byte_shifter.sv
// Purpose: Gathers eight bits MSB first and counts the ninth clock
// Assumes: Edge pulses from the line sampler
// Notes:   Any start or stop restarts the count
`timescale 1ns/1ps
`default_nettype none
`include "tw_defines.svh"
module byte_shifter (
  input  wire logic clock,
  input  wire logic rst,
  tw_link_if.shifter link
);
  logic [3:0] bitCount;
  logic [7:0] shiftReg;
  logic       lastData;
  logic       lastAck;

  assign lastData       = bitCount == `TW_BYTE_BITS - 4'h1;
  assign lastAck        = bitCount == `TW_BYTE_BITS;
  assign link.byteDone  = link.sclRise & lastData;
  assign link.ninthDone = link.sclRise & lastAck;
  // Byte as it stands at the eighth rise, last bit taken live
  assign link.shiftByte = {shiftReg[6:0], link.sdaLevel};

  // Sample on SCL rise; the acknowledge bit is not shifted
  always_ff @(posedge clock) begin
    if (rst || link.startSeen || link.stopSeen) begin
      bitCount <= 4'h0;
    end else if (link.sclRise) begin
      bitCount <= lastAck ? 4'h0 : bitCount + 4'h1;
    end
  end

  // Data bits enter at the bottom
  always_ff @(posedge clock) begin
    if (rst) begin
      shiftReg <= `TW_RESET_BYTE;
    end else if (link.sclRise && !lastAck) begin
      shiftReg <= {shiftReg[6:0], link.sdaLevel};
    end
  end
endmodule : byte_shifter
`default_nettype wire

//--- design/two_wire_slave_receiver.sv
// Purpose: Slave receiver path of a byte-oriented two-wire interface
// Assumes: Registers on a plain port, read data one cycle later
// Notes:   Slave transmitter and master modes are not built here
//
// Notes on behaviour
// - Answer only when address bits 7:1 match own address bits 7:1.
// - Own address bit 0 set answers general call 0x00, else ignored.
// - Address acknowledged only while acknowledge enable is one.
// - Write bit 0 enters receiving; read bit leaves it to transmitter.
// - Own address with write bit sets the flag with a valid code.
// - Addressed after lost arbitration reports 0x68 or 0x78.
// - Acknowledge enable cleared mid-transfer refuses the next byte.
// - With acknowledge enable zero keep watching, resume when set.
// - Deep sleep: still match address on bus clock and wake part; matched on the system clock here.
// - After wake-up hold SCL low until the flag is cleared.
// - Data register need not hold the last byte after deep sleep.
// - Own address write acknowledged reports 0x60.
// - General call acknowledged reports 0x70.
// - Clearing flag after address receives next byte, ack per enable.
// - Own data byte acknowledged reports 0x80; software reads, clears.
// - After 0x88, clearing flag leaves the device not addressed.
// - General call data reports 0x90 acknowledged, 0x98 refused.
// - Stop or repeated start while addressed reports 0xA0.
`timescale 1ns/1ps
`default_nettype none
`include "tw_defines.svh"
module two_wire_slave_receiver (
  input  wire logic       clock,
  input  wire logic       rst,
  input  wire logic [1:0] regAddr,
  input  wire logic [7:0] regWdata,
  input  wire logic       regWrite,
  input  wire logic       regRead,
  output var  logic [7:0] regRdata,
  input  wire logic       arbLost,
  input  wire logic       deepSleep,
  output var  logic       wakeReq,
  output var  logic       irqFlag,
  input  wire logic       sclIn,
  output var  logic       sclOut,
  output var  logic       sclOe,
  input  wire logic       sdaIn,
  output var  logic       sdaOut,
  output var  logic       sdaOe
);
  import tw_pkg::*;

  // ----------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------
  tw_link_if link ();
  rx_state_t  state;
  rx_state_t  next_state;
  logic [7:0] ownAddress;
  logic [7:0] dataReg;
  logic [7:0] statusCode;
  logic [1:0] prescale;
  logic       ackEnable;
  logic       startReq;
  logic       stopReq;
  logic       writeCollision;
  logic       ifaceEnable;
  logic       irqEnable;
  logic       isGeneral;
  logic       ackPlan;
  logic       ninthSeen;
  logic       gotoIdle;

  // ----------------------------------------------------------
  // Sub-blocks
  // ----------------------------------------------------------
  line_sampler sampler (
    .clock (clock),
    .rst   (rst),
    .sclIn (sclIn),
    .sdaIn (sdaIn),
    .link  (link.sampler)
  );

  byte_shifter shifter (
    .clock (clock),
    .rst   (rst),
    .link  (link.shifter)
  );

  // ----------------------------------------------------------
  // Register decode
  // ----------------------------------------------------------
  // Write strobes per register
  wire ctrlWrite = regWrite && regAddr == `TW_REG_CONTROL;
  wire statWrite = regWrite && regAddr == `TW_REG_STATUS;
  wire dataWrite = regWrite && regAddr == `TW_REG_DATA;
  wire addrWrite = regWrite && regAddr == `TW_REG_ADDRESS;
  // Writing one to the flag bit clears it
  wire flagClear = ctrlWrite && regWdata[`TW_CB_FLAG];

  // Control register as read back
  wire [7:0] ctrlView = {irqFlag, ackEnable, startReq, stopReq,
                         writeCollision, ifaceEnable, 1'b0, irqEnable};
  // Status reads code with the prescaler in the low bits
  wire [7:0] statView = {statusCode[7:2], prescale};

  // Read selection
  wire [7:0] readMux =
    regAddr == `TW_REG_CONTROL ? ctrlView :
    regAddr == `TW_REG_STATUS  ? statView :
    regAddr == `TW_REG_DATA    ? dataReg  : ownAddress;

  // ----------------------------------------------------------
  // Address recognition
  // ----------------------------------------------------------
  // own address match
  wire ownMatch = link.shiftByte[7:1] == ownAddress[7:1];
  wire genMatch = link.shiftByte[7:1] == `TW_GEN_CALL_ADDR
                  && ownAddress[0];
  wire addrHit  = ackEnable && !link.shiftByte[0]
                  && (ownMatch || genMatch);
  // General call only when own address does not match too
  wire hitGen   = genMatch && !ownMatch;

  wire [7:0] addrCode =
    arbLost ? (hitGen ? `TW_ST_ARB_GEN  : `TW_ST_ARB_OWN)
            : (hitGen ? `TW_ST_GEN_ADDR : `TW_ST_OWN_ADDR);

  // data codes by address kind and answer
  wire [7:0] dataCode =
    isGeneral ? (ackPlan ? `TW_ST_GEN_ACK : `TW_ST_GEN_NACK)
              : (ackPlan ? `TW_ST_OWN_ACK : `TW_ST_OWN_NACK);

  // ----------------------------------------------------------
  // Bus events
  // ----------------------------------------------------------
  wire inAck     = state == S_ACKA || state == S_ACKD;
  wire addressed = inAck || state == S_DATA;
  // Ninth clock has ended: flag the byte
  wire ackEnd    = inAck && link.sclFall && ninthSeen;
  wire condEvent = addressed && (link.startSeen || link.stopSeen);
  // Hardware raises the flag on these
  wire postEvent = ackEnd || condEvent;
  wire [7:0] postCode = condEvent ? `TW_ST_STOP_RESTRT :
                        state == S_ACKA ? statusCode : dataCode;

  // ----------------------------------------------------------
  // Receive state machine
  // ----------------------------------------------------------
  // Next state
  always_comb begin
    next_state = state;
    case (state)
      S_IDLE: begin
        if (link.startSeen) begin
          next_state = S_ADDR;
        end
      end
      S_ADDR: begin
        if (link.byteDone) begin
          next_state = addrHit ? S_ACKA : S_SKIP;
        end
      end
      S_ACKA, S_ACKD: begin
        if (ackEnd) begin
          next_state = S_WAIT;
        end
      end
      S_DATA: begin
        if (link.byteDone) begin
          next_state = S_ACKD;
        end
      end
      S_WAIT: begin
        if (flagClear) begin
          next_state = gotoIdle ? S_IDLE : S_DATA;
        end
      end
      S_SKIP: begin
        next_state = S_SKIP;
      end
      default: begin
        next_state = S_IDLE;
      end
    endcase
    if (state != S_WAIT) begin
      if (link.stopSeen) begin
        next_state = S_IDLE;
      end else if (link.startSeen) begin
        next_state = S_ADDR;
      end
    end
    if (!ifaceEnable) begin
      next_state = S_IDLE;
    end
  end

  // State register
  always_ff @(posedge clock) begin
    if (rst) begin
      state <= S_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // ----------------------------------------------------------
  // Transfer bookkeeping
  // ----------------------------------------------------------
  // Kind of address and planned answer of the byte
  always_ff @(posedge clock) begin
    if (rst) begin
      isGeneral <= 1'b0;
      ackPlan   <= 1'b0;
      gotoIdle  <= 1'b0;
    end else if (state == S_ADDR && link.byteDone) begin
      isGeneral <= hitGen;
      ackPlan   <= 1'b1;
      gotoIdle  <= 1'b0;
    end else if (state == S_DATA && link.byteDone) begin
      ackPlan   <= ackEnable;
      gotoIdle  <= !ackEnable;
    end
  end

  // Ninth clock seen inside an acknowledge slot
  always_ff @(posedge clock) begin
    if (rst || !inAck) begin
      ninthSeen <= 1'b0;
    end else if (link.ninthDone) begin
      ninthSeen <= 1'b1;
    end
  end

  // ----------------------------------------------------------
  // Pin drivers
  // ----------------------------------------------------------
  // Low-drive levels; the enables decide the wire
  always_ff @(posedge clock) begin
    if (rst) begin
      sclOut <= 1'b0;
      sdaOut <= 1'b0;
    end else begin
      sclOut <= 1'b0;
      sdaOut <= 1'b0;
    end
  end

  // SDA low through the ninth clock when acknowledging
  always_ff @(posedge clock) begin
    if (rst || !inAck || ackEnd) begin
      sdaOe <= 1'b0;
    end else if (link.sclFall && !ninthSeen) begin
      sdaOe <= ackPlan;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      sclOe <= 1'b0;
    end else if (ackEnd) begin
      sclOe <= 1'b1;
    end else if (flagClear || state != S_WAIT) begin
      sclOe <= 1'b0;
    end
  end

  // ----------------------------------------------------------
  // Flag, status and wake
  // ----------------------------------------------------------
  // set wins over a clear in the same cycle
  always_ff @(posedge clock) begin
    if (rst) begin
      irqFlag <= 1'b0;
    end else begin
      irqFlag <= postEvent || (irqFlag && !flagClear);
    end
  end

  // Code latched at address end, then at each event
  always_ff @(posedge clock) begin
    if (rst) begin
      statusCode <= `TW_ST_IDLE;
    end else if (state == S_ADDR && link.byteDone && addrHit) begin
      statusCode <= addrCode;
    end else if (postEvent) begin
      statusCode <= postCode;
    end else if (flagClear && (gotoIdle || state != S_WAIT)) begin
      statusCode <= `TW_ST_IDLE;
    end
  end

  // match in deep sleep wakes the part
  always_ff @(posedge clock) begin
    if (rst) begin
      wakeReq <= 1'b0;
    end else if (ackEnd && state == S_ACKA && deepSleep) begin
      wakeReq <= 1'b1;
    end else if (flagClear) begin
      wakeReq <= 1'b0;
    end
  end

  // ----------------------------------------------------------
  // Software registers
  // ----------------------------------------------------------
  // control written by software
  always_ff @(posedge clock) begin
    if (rst) begin
      ackEnable   <= 1'b0;
      startReq    <= 1'b0;
      stopReq     <= 1'b0;
      ifaceEnable <= 1'b0;
      irqEnable   <= 1'b0;
    end else if (ctrlWrite) begin
      ackEnable   <= regWdata[`TW_CB_ACK];
      startReq    <= regWdata[`TW_CB_START];
      stopReq     <= regWdata[`TW_CB_STOP];
      ifaceEnable <= regWdata[`TW_CB_ENABLE];
      irqEnable   <= regWdata[`TW_CB_IRQEN];
    end
  end

  // Data write while the flag is low is a collision
  always_ff @(posedge clock) begin
    if (rst) begin
      writeCollision <= 1'b0;
    end else if (dataWrite) begin
      writeCollision <= !irqFlag;
    end
  end

  // Own address and prescaler bits
  always_ff @(posedge clock) begin
    if (rst) begin
      ownAddress <= `TW_RESET_BYTE;
      prescale   <= 2'h0;
    end else begin
      if (addrWrite) begin
        ownAddress <= regWdata;
      end
      if (statWrite) begin
        prescale <= regWdata[`TW_PRESC_MSB:0];
      end
    end
  end

  // received byte skipped in deep sleep
  always_ff @(posedge clock) begin
    if (rst) begin
      dataReg <= `TW_RESET_BYTE;
    end else if (state == S_DATA && link.byteDone && !deepSleep) begin
      dataReg <= link.shiftByte;
    end else if (dataWrite && irqFlag) begin
      dataReg <= regWdata;
    end
  end

  // Read data one cycle after the strobe
  always_ff @(posedge clock) begin
    if (rst) begin
      regRdata <= `TW_RESET_BYTE;
    end else if (regRead) begin
      regRdata <= readMux;
    end else begin
      regRdata <= `TW_RESET_BYTE;
    end
  end
endmodule : two_wire_slave_receiver
`default_nettype wire

//--- bench/tw_slave_checker_properties.sv
// Purpose: Concurrent checks on the slave receiver top ports
// Assumes: One clock domain, synchronous active-high reset
// Notes:   Attached by bind below the module
`timescale 1ns/1ps
`default_nettype none
module tw_slave_checker (
  input wire logic       clock,
  input wire logic       rst,
  input wire logic [1:0] regAddr,
  input wire logic [7:0] regWdata,
  input wire logic       regWrite,
  input wire logic [7:0] regRdata,
  input wire logic       deepSleep,
  input wire logic       wakeReq,
  input wire logic       irqFlag,
  input wire logic       sclOut,
  input wire logic       sclOe,
  input wire logic       sdaOut,
  input wire logic       sdaOe
);
  // ----------------------------------------------------------
  // Control bits as software last wrote them
  // ----------------------------------------------------------
  logic ackEnable;
  logic ifaceOn;
  wire  ctrlWrite = regWrite && regAddr == 2'h0;
  wire  flagClear = ctrlWrite && regWdata[7];

  // Shadow of acknowledge enable and interface enable
  always_ff @(posedge clock) begin
    if (rst) begin
      ackEnable <= 1'b0;
      ifaceOn   <= 1'b0;
    end else if (ctrlWrite) begin
      ackEnable <= regWdata[6];
      ifaceOn   <= regWdata[2];
    end
  end

  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  property p_pins_low;
    sclOut == 1'b0 && sdaOut == 1'b0;
  endproperty
  a_pins_low: assert property (p_pins_low)
    else $error("open-drain data level not low");
  property p_ack_enable;
    $rose(sdaOe) |-> $past(ackEnable) && $past(ifaceOn);
  endproperty
  a_ack_enable: assert property (p_ack_enable)
    else $error("acknowledge without enable");
  property p_ack_end;
    $fell(sdaOe) |-> $rose(irqFlag) && sclOe;
  endproperty
  a_ack_end: assert property (p_ack_end)
    else $error("flag did not rise at acknowledge end");
  property p_ack_len;
    $rose(sdaOe) |-> ##[1:40] !sdaOe;
  endproperty
  a_ack_len: assert property (p_ack_len)
    else $error("acknowledge held too long");
  property p_stretch_flag;
    sclOe |-> irqFlag;
  endproperty
  a_stretch_flag: assert property (p_stretch_flag)
    else $error("clock held low with flag clear");
  property p_stretch_hold;
    sclOe && !flagClear |=> sclOe && irqFlag;
  endproperty
  a_stretch_hold: assert property (p_stretch_hold)
    else $error("clock released before flag clear");
  property p_clear;
    sclOe && flagClear |=> !irqFlag && !sclOe;
  endproperty
  a_clear: assert property (p_clear)
    else $error("flag clear did not release clock");
  property p_flag_hold;
    irqFlag && !flagClear |=> irqFlag;
  endproperty
  a_flag_hold: assert property (p_flag_hold)
    else $error("flag dropped by itself");
  property p_wake_rise;
    $rose(wakeReq) |-> $past(deepSleep);
  endproperty
  a_wake_rise: assert property (p_wake_rise)
    else $error("wake request outside sleep");
  property p_wake_clear;
    wakeReq && flagClear |=> !wakeReq;
  endproperty
  a_wake_clear: assert property (p_wake_clear)
    else $error("wake request kept after clear");
endmodule : tw_slave_checker

bind two_wire_slave_receiver tw_slave_checker chk_u (
  .clock(clock), .rst(rst), .regAddr(regAddr), .regWdata(regWdata),
  .regWrite(regWrite), .regRdata(regRdata), .deepSleep(deepSleep),
  .wakeReq(wakeReq), .irqFlag(irqFlag), .sclOut(sclOut),
  .sclOe(sclOe), .sdaOut(sdaOut), .sdaOe(sdaOe));
`default_nettype wire

//--- bench/tw_master_model.sv
// Purpose: Remote master transmitter on the two-wire link
// Assumes: Open-drain lines with pull-ups, 64 ns link period
// Notes:   Link clock stands still between frames
`timescale 1ns/1ps
`default_nettype none
module tw_master_model (
  input  wire logic clock,
  input  wire logic sclLine,
  input  wire logic sdaLine,
  output var  logic sclLow,
  output var  logic sdaLow
);
  localparam int Q = 16; // Quarter of the link period

  initial begin
    sclLow = 1'b0;
    sdaLow = 1'b0;
  end

  // ----------------------------------------------------------
  // Line actions, off the system clock edge
  // ----------------------------------------------------------
  // waits out stretch
  task automatic pulse(output logic seen);
    sclLow = 1'b0;
    wait (sclLine);
    #1;
    #Q seen = sdaLine;
    #Q sclLow = 1'b1;
    #Q;
  endtask : pulse

  // Start or repeated start: data falls while clock is high
  task automatic bus_start();
    @(posedge clock);
    #1 sdaLow = 1'b0;
    #Q sclLow = 1'b0;
    wait (sclLine);
    #1;
    #Q sdaLow = 1'b1;
    #Q sclLow = 1'b1;
    #Q;
  endtask : bus_start

  // Stop: data rises while clock is high, both lines left free
  task automatic bus_stop();
    @(posedge clock);
    #1 sdaLow = 1'b1;
    #Q sclLow = 1'b0;
    wait (sclLine);
    #1;
    #Q sdaLow = 1'b0;
    #(2 * Q);
  endtask : bus_stop

  // Eight bits most significant first, then the acknowledge slot
  task automatic bus_byte(input logic [7:0] b, output logic acked);
    logic seen;
    @(posedge clock);
    #1;
    for (int i = 7; i >= 0; i--) begin
      sdaLow = !b[i];
      #Q pulse(seen);
    end
    sdaLow = 1'b0;
    #Q pulse(seen);
    acked = !seen;
  endtask : bus_byte
endmodule : tw_master_model
`default_nettype wire

//--- bench/two_wire_slave_receiver_bench.sv
// Purpose: Self-checking bench of the two-wire slave receiver
// Assumes: Master model on the link, registers on the plain port
// Notes:   Expected codes use prescaler bits masked off
`timescale 1ns/1ps
`default_nettype none
`define CHECK_EQ(what, exp, got) \
  begin \
    n_compared++; \
    if ((got) !== (exp)) begin \
      num_errors++; \
      $display("mismatch %s expected %0h seen %0h", what, exp, got); \
    end \
  end
module two_wire_slave_receiver_bench;
  logic       clock = 1'b0;
  logic       rst = 1'b1;
  logic [1:0] regAddr = 2'h0;
  logic [7:0] regWdata = 8'h00;
  logic       regWrite = 1'b0;
  logic       regRead = 1'b0;
  logic       arbLost = 1'b0;
  logic       deepSleep = 1'b0;
  logic [7:0] regRdata;
  logic       wakeReq, irqFlag, sclOut, sclOe, sdaOut, sdaOe;
  logic       sclLow, sdaLow;
  int         num_errors = 0;
  int         n_compared = 0;
  int         cycles = 0;
  // Wired-and of pulled-up lines
  wire sclLine = (sclOe ? sclOut : 1'b1) && !sclLow;
  wire sdaLine = (sdaOe ? sdaOut : 1'b1) && !sdaLow;

  two_wire_slave_receiver dut_u (
    .clock(clock), .rst(rst), .regAddr(regAddr), .regWdata(regWdata),
    .regWrite(regWrite), .regRead(regRead), .regRdata(regRdata),
    .arbLost(arbLost), .deepSleep(deepSleep), .wakeReq(wakeReq),
    .irqFlag(irqFlag), .sclIn(sclLine), .sclOut(sclOut), .sclOe(sclOe),
    .sdaIn(sdaLine), .sdaOut(sdaOut), .sdaOe(sdaOe));
  tw_master_model master_u (
    .clock(clock), .sclLine(sclLine), .sdaLine(sdaLine),
    .sclLow(sclLow), .sdaLow(sdaLow));

  // ----------------------------------------------------------
  // Clock, hang guard and verdict
  // ----------------------------------------------------------
  always #2 clock = !clock;
  always @(posedge clock) begin
    cycles++;
    if (cycles == 20000) begin
      num_errors++;
      give_verdict();
    end
  end
  task automatic give_verdict();
    $display("compared %0d mismatches %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : give_verdict

  // Register port cycles
  task automatic reg_write(input logic [1:0] a, input logic [7:0] d);
    @(posedge clock);
    regAddr  <= a;
    regWdata <= d;
    regWrite <= 1'b1;
    @(posedge clock);
    regWrite <= 1'b0;
  endtask : reg_write
  task automatic reg_check(input logic [1:0] a, input logic [7:0] m,
                           input logic [7:0] exp, input string what);
    @(posedge clock);
    regAddr <= a;
    regRead <= 1'b1;
    @(posedge clock);
    regRead <= 1'b0;
    #1;
    `CHECK_EQ(what, exp, regRdata & m)
  endtask : reg_check

  // One byte sent, then acknowledge, flag, code and data judged
  task automatic step(input logic [7:0] b, input logic ack,
                      input logic [7:0] code, input logic [7:0] ctrl);
    logic acked;
    master_u.bus_byte(b, acked);
    `CHECK_EQ("acknowledge", ack, acked)
    repeat (4) @(posedge clock);
    #1;
    `CHECK_EQ("flag", code != 8'hF8, irqFlag)
    `CHECK_EQ("stretch", code != 8'hF8, sclOe)
    reg_check(2'h1, 8'hFC, code, "status");
    if (code[7] && code != 8'hF8)
      reg_check(2'h2, 8'hFF, b, "data");
    if (code != 8'hF8 && ctrl != 8'h00)
      reg_write(2'h0, ctrl);
  endtask : step

  // Stop condition, then the addressed case reports and is cleared
  task automatic end_frame(input logic addressed);
    master_u.bus_stop();
    repeat (4) @(posedge clock);
    #1;
    `CHECK_EQ("stop flag", addressed, irqFlag)
    `CHECK_EQ("stop stretch", 1'b0, sclOe)
    if (addressed) begin
      reg_check(2'h1, 8'hFC, 8'hA0, "stop status");
      reg_write(2'h0, 8'hC4);
    end
    reg_check(2'h1, 8'hFC, 8'hF8, "idle status");
  endtask : end_frame

  // ----------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------
  task automatic test_registers();
    reg_check(2'h0, 8'hFF, 8'h00, "control reset");
    reg_check(2'h1, 8'hFF, 8'hF8, "status reset");
    reg_check(2'h2, 8'hFF, 8'h00, "data reset");
    reg_check(2'h3, 8'hFF, 8'h00, "address reset");
    reg_write(2'h3, 8'h53);
    reg_check(2'h3, 8'hFF, 8'h53, "address readback");
    reg_write(2'h2, 8'h77);
    reg_check(2'h0, 8'h08, 8'h08, "write collision");
    reg_write(2'h0, 8'h44);
    reg_check(2'h0, 8'hF7, 8'h44, "control readback");
    $display("test registers done");
  endtask : test_registers
  task automatic test_own();
    logic [7:0] other [3] = '{8'h53, 8'hD2, 8'h50};
    master_u.bus_start();
    step(8'h52, 1'b1, 8'h60, 8'hC4);
    step(8'hA5, 1'b1, 8'h80, 8'h84);
    step(8'h3C, 1'b0, 8'h88, 8'hC4);
    step(8'h5A, 1'b0, 8'hF8, 8'h00);
    end_frame(1'b0);
    foreach (other[i]) begin
      master_u.bus_start();
      step(other[i], 1'b0, 8'hF8, 8'h00);
      end_frame(1'b0);
    end
    $display("test own address done");
  endtask : test_own
  task automatic test_general();
    master_u.bus_start();
    step(8'h00, 1'b1, 8'h70, 8'hC4);
    step(8'h11, 1'b1, 8'h90, 8'h84);
    step(8'h22, 1'b0, 8'h98, 8'hC4);
    end_frame(1'b0);
    master_u.bus_start();
    step(8'h00, 1'b1, 8'h70, 8'hC4);
    step(8'h33, 1'b1, 8'h90, 8'hC4);
    end_frame(1'b1);
    reg_write(2'h3, 8'h52);
    master_u.bus_start();
    step(8'h00, 1'b0, 8'hF8, 8'h00);
    end_frame(1'b0);
    reg_write(2'h3, 8'h53);
    $display("test general call done");
  endtask : test_general
  task automatic test_ack_off();
    reg_write(2'h0, 8'h04);
    master_u.bus_start();
    step(8'h52, 1'b0, 8'hF8, 8'h00);
    end_frame(1'b0);
    reg_write(2'h0, 8'h44);
    master_u.bus_start();
    step(8'h52, 1'b1, 8'h60, 8'hC4);
    end_frame(1'b1);
    $display("test acknowledge off done");
  endtask : test_ack_off

  task automatic test_arb_sleep();
    @(posedge clock);
    arbLost <= 1'b1;
    master_u.bus_start();
    step(8'h52, 1'b1, 8'h68, 8'hC4);
    end_frame(1'b1);
    master_u.bus_start();
    step(8'h00, 1'b1, 8'h78, 8'hC4);
    end_frame(1'b1);
    @(posedge clock);
    arbLost   <= 1'b0;
    deepSleep <= 1'b1;
    master_u.bus_start();
    step(8'h52, 1'b1, 8'h60, 8'h00);
    repeat (20) @(posedge clock);
    #1;
    `CHECK_EQ("wake", 1'b1, wakeReq)
    `CHECK_EQ("wake stretch", 1'b1, sclOe)
    reg_write(2'h0, 8'hC4);
    @(posedge clock);
    deepSleep <= 1'b0;
    #1;
    `CHECK_EQ("wake clear", 1'b0, wakeReq)
    `CHECK_EQ("wake release", 1'b0, sclOe)
    end_frame(1'b1);
    $display("test arbitration and sleep done");
  endtask : test_arb_sleep

  initial begin
    repeat (5) @(posedge clock);
    rst <= 1'b0;
    repeat (4) @(posedge clock);
    test_registers();
    test_own();
    test_general();
    test_ack_off();
    test_arb_sleep();
    give_verdict();
  end
endmodule : two_wire_slave_receiver_bench
`default_nettype wire
